// ---- include/ssr_pkg.sv ----
package ssr_pkg;

    // word indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL       = 6'h12;
    localparam logic [5:0] IDX_STATUS     = 6'h30;
    localparam logic [5:0] IDX_WATCH_RATE = 6'h31;
    localparam logic [5:0] IDX_STANDBY_RATE_CODE   = 6'h32;

    // control register layout
    localparam int          WATCH_LSB  = 0;
    localparam int          WATCH_W    = 4;
    localparam int          ZERO_BIT   = 4;
    localparam int          STB_LSB    = 5;
    localparam int          STB_W      = 3;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [7:0]  CTRL_WMASK = 8'hEF;

    // status register layout
    localparam int ST_WATCH_OK = 0;
    localparam int ST_STB_OK   = 1;
    localparam int ST_MODE_OK  = 2;
    localparam int ST_LISTED   = 3;

    // trigger count above which the listed rates hold
    localparam int TRIG_MIN = 1;

    typedef enum logic [2:0] {
        SSR_PM_LOW  = 3'b000,
        SSR_PM_ULP  = 3'b011,
        SSR_PM_PREC = 3'b100
    } ssr_pmode_t;

    // rates in units of 0.1 Hz
    typedef struct packed {
        logic [15:0] watch_dhz;
        logic        watch_ok;
        logic [15:0] stb_dhz;
        logic        stb_ok;
        logic        mode_ok;
        logic        listed;
    } ssr_rates_t;

endpackage

// ---- logic/ssr_rate_select.sv ----
`timescale 1ns/1ns
// watch and standby rate selection with register access
module ssr_rate_select #(
    parameter int TRIG_W = 6
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic                   wb_ack_o,
    output logic      [31:0]       wb_dat_o,
    input  wire logic [2:0]        power_mode,
    input  wire logic [TRIG_W-1:0] trigger_count,
    output ssr_pkg::ssr_rates_t    rates
);

    logic [7:0]          ctrl_r;
    logic [7:0]          ctrl_nxt;
    ssr_pkg::ssr_rates_t rates_r;
    ssr_pkg::ssr_rates_t rates_nxt;
    logic                wr_en;
    logic [5:0]          reg_idx;
    logic [31:0]         rd_data;
    logic [3:0]          watch_code;
    logic [2:0]          stb_code;
    logic [16:0]         watch_lu;
    logic [16:0]         stb_lu;
    logic                mode_ok;

    // watch rate table, ultra-low power column; n/a returns zero
    function automatic logic [16:0] watch_ulp(input logic [3:0] c);
        case (c)
            4'h0:    watch_ulp = {1'b1, 16'h003C};
            4'h1:    watch_ulp = {1'b1, 16'h0004};
            4'h2:    watch_ulp = {1'b1, 16'h0008};
            4'h3:    watch_ulp = {1'b1, 16'h000F};
            4'h4:    watch_ulp = {1'b1, 16'h003C};
            4'h5:    watch_ulp = {1'b1, 16'h0082};
            4'h6:    watch_ulp = {1'b1, 16'h00FA};
            4'h7:    watch_ulp = {1'b1, 16'h01F4};
            4'h8:    watch_ulp = {1'b1, 16'h03E8};
            4'h9:    watch_ulp = {1'b1, 16'h076C};
            4'hA:    watch_ulp = {1'b1, 16'h0ED8};
            4'hB:    watch_ulp = {1'b1, 16'h1D4C};
            4'hC:    watch_ulp = {1'b1, 16'h2AF8};
            4'hF:    watch_ulp = {1'b1, 16'h32C8};
            default: watch_ulp = 17'h0_0000;
        endcase
    endfunction

    // watch rate table, low power column
    function automatic logic [16:0] watch_low(input logic [3:0] c);
        case (c)
            4'h0:    watch_low = {1'b1, 16'h0046};
            4'h1:    watch_low = {1'b1, 16'h0004};
            4'h2:    watch_low = {1'b1, 16'h0008};
            4'h3:    watch_low = {1'b1, 16'h000F};
            4'h4:    watch_low = {1'b1, 16'h0046};
            4'h5:    watch_low = {1'b1, 16'h008C};
            4'h6:    watch_low = {1'b1, 16'h0118};
            4'h7:    watch_low = {1'b1, 16'h021C};
            4'h8:    watch_low = {1'b1, 16'h041A};
            4'h9:    watch_low = {1'b1, 16'h0834};
            4'hA:    watch_low = {1'b1, 16'h0FA0};
            4'hB:    watch_low = {1'b1, 16'h1770};
            4'hF:    watch_low = {1'b1, 16'h1D4C};
            default: watch_low = 17'h0_0000;
        endcase
    endfunction

    // watch rate table, precision column
    function automatic logic [16:0] watch_prec(input logic [3:0] c);
        case (c)
            4'h0:    watch_prec = {1'b1, 16'h0046};
            4'h1:    watch_prec = {1'b1, 16'h0002};
            4'h2:    watch_prec = {1'b1, 16'h0004};
            4'h3:    watch_prec = {1'b1, 16'h0009};
            4'h4:    watch_prec = {1'b1, 16'h0046};
            4'h5:    watch_prec = {1'b1, 16'h008C};
            4'h6:    watch_prec = {1'b1, 16'h0118};
            4'h7:    watch_prec = {1'b1, 16'h0226};
            4'h8:    watch_prec = {1'b1, 16'h0320};
            4'hF:    watch_prec = {1'b1, 16'h03E8};
            default: watch_prec = 17'h0_0000;
        endcase
    endfunction

    // standby clock table; every code is defined in every mode
    function automatic logic [15:0] standby_rate_code(input logic [2:0] c,
                                             input logic [2:0] pm);
        logic [15:0] r;
        r = 16'h0000;
        case (pm)
            ssr_pkg::SSR_PM_ULP: begin
                case (c)
                    3'h0:    r = 16'h000A;
                    3'h1:    r = 16'h001E;
                    3'h2:    r = 16'h0032;
                    3'h3:    r = 16'h0064;
                    3'h4:    r = 16'h00E6;
                    3'h5:    r = 16'h01C2;
                    3'h6:    r = 16'h0384;
                    default: r = 16'h0708;
                endcase
            end
            ssr_pkg::SSR_PM_LOW: begin
                case (c)
                    3'h0:    r = 16'h0005;
                    3'h1:    r = 16'h000A;
                    3'h2:    r = 16'h001E;
                    3'h3:    r = 16'h003C;
                    3'h4:    r = 16'h0078;
                    3'h5:    r = 16'h00F0;
                    3'h6:    r = 16'h01E0;
                    default: r = 16'h03E8;
                endcase
            end
            ssr_pkg::SSR_PM_PREC: begin
                case (c)
                    3'h0:    r = 16'h0001;
                    3'h1:    r = 16'h0002;
                    3'h2:    r = 16'h0004;
                    3'h3:    r = 16'h0008;
                    3'h4:    r = 16'h000F;
                    3'h5:    r = 16'h001E;
                    3'h6:    r = 16'h0032;
                    default: r = 16'h0064;
                endcase
            end
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    ssr_wb_slave u_bus (
        .clock    (clock),
        .rst_n    (rst_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .rd_data  (rd_data),
        .wb_ack_o (wb_ack_o),
        .wb_dat_o (wb_dat_o),
        .wr_en    (wr_en),
        .reg_idx  (reg_idx)
    );

    // bit four is never stored, so a careless write cannot set it
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_en && reg_idx == ssr_pkg::IDX_CTRL) begin
            ctrl_nxt = wb_dat_i[7:0] & ssr_pkg::CTRL_WMASK;
        end
    end

    assign watch_code = ctrl_r[ssr_pkg::WATCH_LSB +: ssr_pkg::WATCH_W];
    assign stb_code   = ctrl_r[ssr_pkg::STB_LSB +: ssr_pkg::STB_W];

    // column choice follows the power mode field
    always_comb begin
        mode_ok  = 1'b1;
        watch_lu = 17'h0_0000;
        case (power_mode)
            ssr_pkg::SSR_PM_ULP:  watch_lu = watch_ulp(watch_code);
            ssr_pkg::SSR_PM_LOW:  watch_lu = watch_low(watch_code);
            ssr_pkg::SSR_PM_PREC: watch_lu = watch_prec(watch_code);
            default:              mode_ok  = 1'b0;
        endcase
        stb_lu = {mode_ok, standby_rate_code(stb_code, power_mode)};
    end

    // rates are approximate maxima; listed only above one trigger
    always_comb begin
        rates_nxt.watch_dhz = watch_lu[15:0];
        rates_nxt.watch_ok  = watch_lu[16];
        rates_nxt.stb_dhz   = stb_lu[15:0];
        rates_nxt.stb_ok    = stb_lu[16];
        rates_nxt.mode_ok   = mode_ok;
        rates_nxt.listed    = mode_ok &&
            (int'(trigger_count) > ssr_pkg::TRIG_MIN);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_r  <= ssr_pkg::CTRL_RESET;
            rates_r <= '0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            rates_r <= rates_nxt;
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (reg_idx)
            ssr_pkg::IDX_CTRL:       rd_data[7:0] = ctrl_r;
            ssr_pkg::IDX_STATUS: begin
                rd_data[ssr_pkg::ST_WATCH_OK] = rates_r.watch_ok;
                rd_data[ssr_pkg::ST_STB_OK]   = rates_r.stb_ok;
                rd_data[ssr_pkg::ST_MODE_OK]  = rates_r.mode_ok;
                rd_data[ssr_pkg::ST_LISTED]   = rates_r.listed;
            end
            ssr_pkg::IDX_WATCH_RATE: rd_data[15:0] = rates_r.watch_dhz;
            ssr_pkg::IDX_STANDBY_RATE_CODE:   rd_data[15:0] = rates_r.stb_dhz;
            default:                 rd_data = 32'h0000_0000;
        endcase
    end

    assign rates = rates_r;

endmodule

// ---- logic/ssr_wb_slave.sv ----
`timescale 1ns/1ns
// classic wishbone slave front end, one wait state per access
module ssr_wb_slave (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] rd_data,
    output logic             wb_ack_o,
    output logic      [31:0] wb_dat_o,
    output logic             wr_en,
    output logic      [5:0]  reg_idx
);

    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    logic        req;

    // a request is served once; ack low again in the following cycle
    assign req     = wb_cyc_i & wb_stb_i & ~ack_r;
    assign reg_idx = wb_adr_i[7:2];
    // the write lands at the edge where the master samples ack, while the
    // request still stands; only lane 0 holds data
    assign wr_en   = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];

    always_comb begin
        ack_nxt = req;
        dat_nxt = dat_r;
        if (req) begin
            dat_nxt = wb_we_i ? 32'h0000_0000 : rd_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

endmodule

// ---- testbench/sniff_standby_rate_select_tb.sv ----
`timescale 1ns/1ns
module sniff_standby_rate_select_tb;
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    logic                cyc, stb, we, ack;
    logic [7:0]          adr;
    logic [3:0]          sel;
    logic [31:0]         dat, dat_o, q;
    logic [2:0]          pm = 3'h3;
    logic [5:0]          tc = 6'h02;
    ssr_pkg::ssr_rates_t rates;
    int                  error_cnt = 0;
    int                  check_count = 0;
    // expected rates in 0.1 Hz, rows ultra-low, low, precision
    localparam logic [2:0]  PMC [3] = '{3'h3, 3'h0, 3'h4};
    localparam logic [15:0] WR [3][16] = '{
        '{16'h3C, 16'h4, 16'h8, 16'hF, 16'h3C, 16'h82, 16'hFA, 16'h1F4,
          16'h3E8, 16'h76C, 16'hED8, 16'h1D4C, 16'h2AF8, 16'h0, 16'h0,
          16'h32C8},
        '{16'h46, 16'h4, 16'h8, 16'hF, 16'h46, 16'h8C, 16'h118, 16'h21C,
          16'h41A, 16'h834, 16'hFA0, 16'h1770, 16'h0, 16'h0, 16'h0,
          16'h1D4C},
        '{16'h46, 16'h2, 16'h4, 16'h9, 16'h46, 16'h8C, 16'h118, 16'h226,
          16'h320, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3E8}};
    localparam logic [15:0] SR [3][8] = '{
        '{16'hA, 16'h1E, 16'h32, 16'h64, 16'hE6, 16'h1C2, 16'h384, 16'h708},
        '{16'h5, 16'hA, 16'h1E, 16'h3C, 16'h78, 16'hF0, 16'h1E0, 16'h3E8},
        '{16'h1, 16'h2, 16'h4, 16'h8, 16'hF, 16'h1E, 16'h32, 16'h64}};

    // clock at 20 MHz
    initial begin
        forever #25 clock = ~clock;
    end

    ssr_host_model u_host (.clock(clock), .ack(ack), .rdat(dat_o),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat));
    ssr_rate_select #(.TRIG_W(6)) u_dut (.clock(clock), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(dat_o),
        .power_mode(pm), .trigger_count(tc), .rates(rates));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // rates are registered: let two edges pass after any input change
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    // every code in every power mode, with readback of ctrl and rate
    task automatic t_sweep();
        logic [7:0] v;
        for (int m = 0; m < 3; m++) begin
            pm <= PMC[m];
            for (int c = 0; c < 16; c++) begin
                v = {c[2:0], 1'b0, c[3:0]};
                u_host.xfer(1'b1, 8'h48, v, q);
                settle();
                chk(rates.watch_dhz, WR[m][c]);
                chk({15'h0, rates.watch_ok}, {15'h0, WR[m][c] != 0});
                chk(rates.stb_dhz, SR[m][c[2:0]]);
                chk({15'h0, rates.listed}, 16'h1);
                u_host.xfer(1'b0, 8'h48, 8'h00, q);
                chk(q[15:0], {8'h00, v});
                u_host.xfer(1'b0, 8'hC4, 8'h00, q);
                chk(q[15:0], WR[m][c]);
                u_host.xfer(1'b0, 8'hC8, 8'h00, q);
                chk(q[15:0], SR[m][c[2:0]]);
                u_host.xfer(1'b0, 8'hC0, 8'h00, q);
                chk(q[15:0], {12'h0, 3'h7, WR[m][c] != 0});
            end
        end
        $display("sweep done");
    endtask

    // trigger count boundary, unknown mode, unmapped read
    task automatic t_edges();
        tc <= 6'h01;
        settle();
        chk({15'h0, rates.listed}, 16'h0);
        // inputs only change on a rising edge
        @(posedge clock);
        tc <= 6'h00;
        settle();
        chk({15'h0, rates.listed}, 16'h0);
        @(posedge clock);
        pm <= 3'h7;
        tc <= 6'h3F;
        settle();
        chk({15'h0, rates.mode_ok}, 16'h0);
        chk(rates.watch_dhz, 16'h0);
        chk(rates.stb_dhz, 16'h0);
        u_host.xfer(1'b0, 8'hC0, 8'h00, q);
        chk(q[15:0], 16'h0);
        u_host.xfer(1'b0, 8'h4C, 8'h00, q);
        chk(q[15:0], 16'h0);
        $display("edges done");
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog well beyond the roughly 850 cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        complete_run();
    end

    // reset for 16 cycles, rates must read zero meanwhile
    initial begin
        repeat (15) @(posedge clock);
        #1;
        chk(rates.watch_dhz | rates.stb_dhz, 16'h0);
        @(posedge clock);
        rst_n <= 1'b1;
        u_host.xfer(1'b0, 8'h48, 8'h00, q);
        chk(q[15:0], 16'h0000);
        $display("reset done");
        t_sweep();
        t_edges();
        complete_run();
    end
endmodule

// ---- testbench/ssr_host_model.sv ----
`timescale 1ns/1ns
// host software model: classic single wishbone cycles into the block
module ssr_host_model (
    input  wire logic        clock,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             stb,
    output logic             we,
    output logic      [7:0]  adr,
    output logic      [3:0]  sel,
    output logic      [31:0] dat
);
    // bus idles released from time zero
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we  = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
    end

    // one access; waits for ack as long as it takes, bench watchdog guards
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] q);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h0, d & 8'hEF};
        do @(posedge clock); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        dat <= ~dat; // released data does not keep its last value
    endtask
endmodule

// ---- testbench/ssr_rate_checker.sv ----
`timescale 1ns/1ns
// port-level checks on the rate selector
module ssr_rate_checker #(
    parameter int TRIG_W = 6
) (
    input wire logic                clock,
    input wire logic                rst_n,
    input wire logic                wb_cyc_i,
    input wire logic                wb_stb_i,
    input wire logic                wb_we_i,
    input wire logic [7:0]          wb_adr_i,
    input wire logic                wb_ack_o,
    input wire logic [31:0]         wb_dat_o,
    input wire logic [2:0]          power_mode,
    input wire logic [TRIG_W-1:0]   trigger_count,
    input wire ssr_pkg::ssr_rates_t rates
);
    // byte address of the control word; 0x4C is an unmapped word
    localparam logic [7:0] CTRL_ADR = {ssr_pkg::IDX_CTRL, 2'b00};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // bus handshake: one ack per taken request, exactly one cycle later
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_taken: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked in one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i && wb_cyc_i))
        else $error("ack without a request");
    // ctrl reads never show bit four, unmapped reads give zero
    a_bit4_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == CTRL_ADR)
        |-> wb_dat_o[ssr_pkg::ZERO_BIT] == 1'b0)
        else $error("bit four read back set");
    a_unmapped_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h4C)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    // mode and listed flags follow inputs with one cycle latency; watch ok agrees with its rate, a valid mode sets standby ok and a nonzero standby rate
    a_mode_valid: assert property (
        $past(rst_n) |-> rates.mode_ok ==
        ($past(power_mode) inside {3'h0, 3'h3, 3'h4}))
        else $error("mode flag wrong");
    a_listed_trig: assert property (
        $past(rst_n) |-> rates.listed ==
        (rates.mode_ok && $past(trigger_count) > ssr_pkg::TRIG_MIN))
        else $error("listed flag wrong");
    a_stb_valid: assert property (
        rates.mode_ok |-> rates.stb_ok && rates.stb_dhz != 16'h0)
        else $error("standby rate missing");
    a_watch_ok: assert property (
        rates.watch_ok == (rates.watch_dhz != 16'h0))
        else $error("watch ok flag disagrees with rate");
endmodule

bind ssr_rate_select ssr_rate_checker #(.TRIG_W(TRIG_W)) u_chk (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .power_mode(power_mode),
    .trigger_count(trigger_count), .rates(rates));
